// ---- src/phy_addr_strap_led_pins.sv ----
// address strap bits 3/4 with tx/rx activity leds, speed indicator and reset handling
`timescale 1ns/1ps
module phy_addr_strap_led_pins
  import phy_strap_pkg::*;
#(
  parameter int SETTLE_CYC = STRAP_SETTLE_CYC
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic hwResetN,
  input wire logic addr3TxLedPinIn,
  output logic addr3TxLedPinOut,
  output logic addr3TxLedPinOe,
  input wire logic addr4RxLedPinIn,
  output logic addr4RxLedPinOut,
  output logic addr4RxLedPinOe,
  input wire logic txActivity,
  input wire logic rxActivity,
  input wire logic speed100Sel,
  output logic speedSelectIndicator,
  output logic [NUM_STRAP_PINS-1:0] phyAddrStrap,
  output logic deviceOperational
);

  // settle must cover the pin synchronisers, and fit the counter
  if (SETTLE_CYC < SYNC_DEPTH + 1 || SETTLE_CYC >= (1 << SETTLE_CNT_W))
    $error("SETTLE_CYC out of range");

  // the package default must itself be a legal settle, so a plain instance elaborates
  if (STRAP_SETTLE_CYC < SYNC_DEPTH + 1)
    $error("STRAP_SETTLE_CYC too short");

  // the synchronisers are a fixed pair of flops; a longer chain would also need a longer settle
  if (SYNC_DEPTH != 2)
    $error("SYNC_DEPTH must be 2");

  // exactly two shared pins, each owning one distinct bit of the strap output
  if (NUM_STRAP_PINS != 2)
    $error("NUM_STRAP_PINS must be 2");

  if (PIN_ADDR3 == PIN_ADDR4)
    $error("strap pin indices overlap");

  if (PIN_ADDR3 < 0 || PIN_ADDR3 >= NUM_STRAP_PINS)
    $error("PIN_ADDR3 out of range");

  if (PIN_ADDR4 < 0 || PIN_ADDR4 >= NUM_STRAP_PINS)
    $error("PIN_ADDR4 out of range");

  if ($bits(phyAddrStrap) != NUM_STRAP_PINS)
    $error("strap width mismatch");

  // the counter must at least hold the shortest legal settle
  if (SETTLE_CNT_W < 2)
    $error("SETTLE_CNT_W too small");

  localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST = SETTLE_CNT_W'(SETTLE_CYC - 1);
  localparam logic [SETTLE_CNT_W-1:0] CNT_ONE = SETTLE_CNT_W'(1);

  logic rstMeta_r;
  logic rstSync_b;
  logic hwMeta_r;
  logic hwSync_r;
  logic [SETTLE_CNT_W-1:0] settleCnt_r;
  pin_state_e state_r;
  pin_state_e state_nxt;
  logic speed_r;
  logic oper_r;
  logic [NUM_STRAP_PINS-1:0] strapBits;
  logic [NUM_STRAP_PINS-1:0] pinIns;
  logic [NUM_STRAP_PINS-1:0] acts;
  logic [NUM_STRAP_PINS-1:0] outs;
  logic [NUM_STRAP_PINS-1:0] oes;
  logic captureNow_r;
  logic driveNow_r;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta_r <= 1'b0;
      rstSync_b <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstSync_b <= rstMeta_r;
    end
  end

  // reset pin is asynchronous to the core clock; reset value means "in reset"
  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      hwMeta_r <= 1'b0;
      hwSync_r <= 1'b0;
    end
    else
    begin
      hwMeta_r <= hwResetN;
      hwSync_r <= hwMeta_r;
    end
  end

  // dwell in reset so a very short reset pulse still yields a settled strap
  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
      settleCnt_r <= '0;
    else if (state_r != ST_RESET)
      settleCnt_r <= '0;
    else if (settleCnt_r != SETTLE_LAST)
      settleCnt_r <= settleCnt_r + CNT_ONE;
  end

  // a hardware reset that lands during capture sends the pins back to strap mode
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RESET:
        if (hwSync_r && settleCnt_r == SETTLE_LAST)
          state_nxt = ST_CAPTURE;
      ST_CAPTURE:
        state_nxt = hwSync_r ? ST_RUN : ST_RESET;
      ST_RUN:
        if (!hwSync_r)
          state_nxt = ST_RESET;
      default:
        state_nxt = ST_RESET;
    endcase
  end

  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
      state_r <= ST_RESET;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
      oper_r <= 1'b0;
    else
      oper_r <= (state_nxt == ST_RUN);
  end

  // pin slices get their strobes from flops aligned with state_r, not from a decode of it
  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
      captureNow_r <= 1'b0;
    else
      captureNow_r <= (state_nxt == ST_CAPTURE);
  end

  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
      driveNow_r <= 1'b0;
    else
      driveNow_r <= (state_nxt == ST_RUN);
  end

  // indicator follows the selected speed only once running
  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
      speed_r <= SPEED_10M_LEVEL;
    else if (state_r == ST_RUN)
      speed_r <= speed100Sel;
    else
      speed_r <= SPEED_10M_LEVEL;
  end

  assign pinIns[PIN_ADDR3] = addr3TxLedPinIn;
  assign pinIns[PIN_ADDR4] = addr4RxLedPinIn;
  assign acts[PIN_ADDR3] = txActivity;
  assign acts[PIN_ADDR4] = rxActivity;

  // one slice per shared pin; both slices share the sequencer's strobes
  strap_led_if pinBus[NUM_STRAP_PINS] ();

  for (genvar i = 0; i < NUM_STRAP_PINS; i++)
  begin : gPin
    assign pinBus[i].pinIn = pinIns[i];
    assign pinBus[i].activity = acts[i];
    assign pinBus[i].capture = captureNow_r;
    assign pinBus[i].drive = driveNow_r;
    assign strapBits[i] = pinBus[i].strapBit;
    assign outs[i] = pinBus[i].pinOut;
    assign oes[i] = pinBus[i].pinOe;

    strap_led_pin uPin
    (
      .clock(clock),
      .rstSync_b(rstSync_b),
      .port(pinBus[i])
    );
  end

  // the pad ring owns the tri-state buffer; this block only supplies value and enable
  assign addr3TxLedPinOut = outs[PIN_ADDR3];
  assign addr3TxLedPinOe = oes[PIN_ADDR3];
  assign addr4RxLedPinOut = outs[PIN_ADDR4];
  assign addr4RxLedPinOe = oes[PIN_ADDR4];
  assign phyAddrStrap = strapBits;
  assign speedSelectIndicator = speed_r;
  assign deviceOperational = oper_r;

endmodule : phy_addr_strap_led_pins

// ---- src/phy_strap_pkg.sv ----
// shared constants for the address-strap / activity-led pin block
package phy_strap_pkg;

  localparam int CLOCK_MHZ = 100;
  localparam int SYNC_DEPTH = 2;

  // pins must have settled and filled their synchronisers before the strap is taken
  localparam int STRAP_SETTLE_NS = 100;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int SETTLE_CNT_W = 8;

  localparam int NUM_STRAP_PINS = 2;
  localparam int PIN_ADDR3 = 0;
  localparam int PIN_ADDR4 = 1;

  localparam logic STRAP_RESET_VAL = 1'b0;
  localparam logic LED_OFF = 1'b0;
  localparam logic SPEED_10M_LEVEL = 1'b0;

  typedef enum logic [1:0]
  {
    ST_RESET = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_RUN = 2'b10
  } pin_state_e;

endpackage : phy_strap_pkg

// ---- src/strap_led_if.sv ----
// carrier between the pin sequencer and one shared strap/led pin
`timescale 1ns/1ps
interface strap_led_if;
  logic pinIn;
  logic pinOut;
  logic pinOe;
  logic activity;
  logic capture;
  logic drive;
  logic strapBit;

  modport pin
  (
    input pinIn,
    input activity,
    input capture,
    input drive,
    output pinOut,
    output pinOe,
    output strapBit
  );

  modport ctl
  (
    output pinIn,
    output activity,
    output capture,
    output drive,
    input pinOut,
    input pinOe,
    input strapBit
  );
endinterface : strap_led_if

// ---- src/strap_led_pin.sv ----
// one shared pin: strap input during reset, activity led output afterwards
`timescale 1ns/1ps
module strap_led_pin
  import phy_strap_pkg::*;
(
  input wire logic clock,
  input wire logic rstSync_b,
  strap_led_if.pin port
);

  logic syncA_r;
  logic syncB_r;
  logic strap_r;
  logic oe_r;
  logic out_r;

  // pin level comes from the board, so it is synchronised before use
  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      syncA_r <= 1'b0;
      syncB_r <= 1'b0;
    end
    else
    begin
      syncA_r <= port.pinIn;
      syncB_r <= syncA_r;
    end
  end

  // strap held until the next reset; later led activity cannot disturb it
  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
      strap_r <= STRAP_RESET_VAL;
    else if (port.capture)
      strap_r <= syncB_r;
  end

  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      oe_r <= 1'b0;
      out_r <= LED_OFF;
    end
    else
    begin
      oe_r <= port.drive;
      out_r <= port.drive ? port.activity : LED_OFF;
    end
  end

  assign port.strapBit = strap_r;
  assign port.pinOe = oe_r;
  assign port.pinOut = out_r;

endmodule : strap_led_pin

// ---- tb/strap_led_props.sv ----
// port checks for the strap/led pin block
`timescale 1ns/1ps
module strap_led_props
  import phy_strap_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic hwResetN,
  input wire logic addr3TxLedPinIn,
  input wire logic addr3TxLedPinOut,
  input wire logic addr3TxLedPinOe,
  input wire logic addr4RxLedPinIn,
  input wire logic addr4RxLedPinOut,
  input wire logic addr4RxLedPinOe,
  input wire logic txActivity,
  input wire logic rxActivity,
  input wire logic speed100Sel,
  input wire logic speedSelectIndicator,
  input wire logic [NUM_STRAP_PINS-1:0] phyAddrStrap,
  input wire logic deviceOperational
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  chk_strap_value: assert property ($rose(addr3TxLedPinOe) |->
    phyAddrStrap == {$past(addr4RxLedPinIn, 4), $past(addr3TxLedPinIn, 4)}) else $error("strap wrong");
  chk_tx_follow: assert property ($past(addr3TxLedPinOe) && addr3TxLedPinOe |->
    addr3TxLedPinOut == $past(txActivity)) else $error("tx led wrong");
  chk_rx_follow: assert property ($past(addr4RxLedPinOe) && addr4RxLedPinOe |->
    addr4RxLedPinOut == $past(rxActivity)) else $error("rx led wrong");
  chk_speed_level: assert property ($past(addr3TxLedPinOe) && addr3TxLedPinOe |->
    speedSelectIndicator == $past(speed100Sel)) else $error("speed wrong");
  chk_off_reset: assert property (!hwResetN [*8] |-> !addr3TxLedPinOe && !deviceOperational)
    else $error("not held in reset");
  chk_strap_hold: assert property ($past(addr3TxLedPinOe) |-> $stable(phyAddrStrap))
    else $error("strap moved");
  chk_oe_pair: assert property (addr3TxLedPinOe == addr4RxLedPinOe) else $error("enables differ");
  chk_oe_after_op: assert property ($rose(addr4RxLedPinOe) |-> deviceOperational)
    else $error("driver early");
  chk_led_dark: assert property (!addr3TxLedPinOe |-> !addr3TxLedPinOut && !addr4RxLedPinOut)
    else $error("led lit while released");
  chk_speed_idle: assert property (!deviceOperational |=> !speedSelectIndicator)
    else $error("speed high outside run");
endmodule : strap_led_props
bind phy_addr_strap_led_pins strap_led_props props (.clock, .rst_b, .hwResetN, .addr3TxLedPinIn,
  .addr3TxLedPinOut, .addr3TxLedPinOe, .addr4RxLedPinIn, .addr4RxLedPinOut, .addr4RxLedPinOe,
  .txActivity, .rxActivity, .speed100Sel, .speedSelectIndicator, .phyAddrStrap, .deviceOperational);

// ---- tb/board_model.sv ----
// board side: strap resistors plus led loads
`timescale 1ns/1ps
module board_model
(
  input wire logic [1:0] strap,
  input wire logic oe3,
  input wire logic out3,
  input wire logic oe4,
  input wire logic out4,
  output logic pin3,
  output logic pin4
);
  // resistor takes over whenever the driver is off
  assign pin3 = oe3 ? out3 : strap[0];
  assign pin4 = oe4 ? out4 : strap[1];
endmodule : board_model

// ---- tb/phy_addr_strap_led_pins_tb.sv ----
// self-checking bench for the strap/led pin block
`timescale 1ns/1ps
module phy_addr_strap_led_pins_tb;
  import phy_strap_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic hwResetN = 1'b0;
  logic txActivity = 1'b0;
  logic rxActivity = 1'b0;
  logic speed100Sel = 1'b0;
  logic [1:0] strap = 2'h0;
  logic pin3, pin4, out3, oe3, out4, oe4, speedInd, operational;
  logic [NUM_STRAP_PINS-1:0] phyAddrStrap;
  logic [1:0] expQ[$];
  logic [2:0] ledQ[$];
  logic stimOn = 1'b0;
  logic ledDue = 1'b0;
  logic oe3Prev = 1'b0;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed = 32'h7e8ef82b;
  always #5 clock = ~clock;
  board_model board (.strap(strap), .oe3(oe3), .out3(out3), .oe4(oe4), .out4(out4), .pin3(pin3), .pin4(pin4));
  phy_addr_strap_led_pins #(.SETTLE_CYC(3)) dut (.clock(clock), .rst_b(rst_b), .hwResetN(hwResetN),
    .addr3TxLedPinIn(pin3), .addr3TxLedPinOut(out3), .addr3TxLedPinOe(oe3), .addr4RxLedPinIn(pin4),
    .addr4RxLedPinOut(out4), .addr4RxLedPinOe(oe4), .txActivity(txActivity), .rxActivity(rxActivity),
    .speed100Sel(speed100Sel), .speedSelectIndicator(speedInd), .phyAddrStrap(phyAddrStrap),
    .deviceOperational(operational));
  task automatic summarize;
    // a capture that never happened leaves its note behind
    if (expQ.size() != 0)
      num_errors++;
    if (ledQ.size() != 0)
      num_errors++;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic check_strap(input logic [1:0] exp);
    n_compared++;
    if (phyAddrStrap !== exp)
    begin
      num_errors++;
      $display("BAD %0t strap %b want %b", $time, phyAddrStrap, exp);
    end
  endtask : check_strap
  task automatic check_leds(input logic [2:0] exp);
    n_compared++;
    if ({oe3, oe4, out3, out4, speedInd, operational} !== {2'b11, exp, 1'b1})
    begin
      num_errors++;
      $display("BAD %0t leds %b want %b", $time,
        {oe3, oe4, out3, out4, speedInd, operational}, {2'b11, exp, 1'b1});
    end
  endtask : check_leds
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors++;
      summarize();
    end
  end
  // outputs are settled by the falling edge; a led result trails its stimulus by one clock
  always @(negedge clock)
  begin
    if (oe3 === 1'b1 && oe3Prev !== 1'b1 && expQ.size() > 0)
      check_strap(expQ.pop_front());
    if (ledDue && ledQ.size() > 0)
      check_leds(ledQ.pop_front());
    ledDue = stimOn;
    oe3Prev = oe3;
  end
  initial
  begin
    logic [2:0] stim;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      hwResetN <= 1'b0;
      strap <= 2'($random(seed));
      repeat (8) @(posedge clock);
      expQ.push_back(strap);
      hwResetN <= 1'b1;
      for (int k = 0; k < 40 && oe3 !== 1'b1; k++)
        @(posedge clock);
      repeat (30)
      begin
        @(posedge clock);
        stim = 3'($random(seed));
        {txActivity, rxActivity, speed100Sel} <= stim;
        stimOn <= 1'b1;
        ledQ.push_back(stim);
      end
      @(posedge clock);
      stimOn <= 1'b0;
    end
    repeat (2) @(posedge clock);
    summarize();
  end
endmodule : phy_addr_strap_led_pins_tb
